/* File: pkg/cprm_cfg.svh */
/*
 * Offsets, field positions, reset values and sizes of the
 * protection receiver tail and repeater mailbox.
 * Assumes word addressing on both register ports.
 */
`ifndef CPRM_CFG_SVH
`define CPRM_CFG_SVH

// upstream-facing register port, word indices
`define CPRM_MSG_IDX 8'h42
`define CPRM_CAPS_IDX 8'h43

// repeater message port, word indices
`define CPRM_LIST_IDX 8'h00
`define CPRM_TOPO_IDX 8'h01
`define CPRM_TYPE_IDX 8'h02
`define CPRM_ROLE_IDX 8'h03

// field positions
`define CPRM_REQ_BIT 18
`define CPRM_RDY_BIT 17
`define CPRM_VLD_BIT 16
`define CPRM_TYPE_VLD_BIT 8
`define CPRM_VER_LSB 16
`define CPRM_NEWREV_BIT 1
`define CPRM_ROLE_BIT 0

// reset values
`define CPRM_ZERO_RST 32'h00000000
`define CPRM_CAPS_RST 32'h00020002
`define CPRM_VERSION 8'h02
`define CPRM_TOPO_RST 16'h0000
`define CPRM_TYPE_RST 8'h00

// id list store: 32 devices of 5 bytes, plus slack
`define CPRM_LIST_DEPTH 256
`define CPRM_LIST_LIMIT 9'h0A0

`endif

/* File: pkg/cprm_pkg.sv */
/*
 * Types of the protection receiver tail and repeater mailbox.
 * Assumes cprm_cfg.svh supplies the numbers.
 */
package cprm_pkg;

    // downstream topology word as the processor supplies it
    typedef struct packed {
        logic [3:0] reserved;
        logic [2:0] cascadeDepth;
        logic [4:0] deviceCount;
        logic too_many_devices_flag;
        logic cascade_limit_flag;
        logic new_rev_repeater_below;
        logic old_rev_device_below;
    } cprm_topology_t;

    typedef enum logic [2:0] {
        MB_IDLE = 3'b001,
        MB_WAIT = 3'b010,
        MB_FULL = 3'b100
    } cprm_mb_state_t;

endpackage

/* File: pkg/cprm_mem_if.sv */
/*
 * Carrier between the mailbox and its id list store.
 * Assumes one clock; read data arrive one cycle after rdAddr.
 */
`timescale 1ns/1ps
interface cprm_mem_if;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] rdAddr;
    logic [7:0] rdData;

    modport ctrl (
        output wrEn,
        output wrAddr,
        output wrData,
        output rdAddr,
        input rdData
    );

    modport mem (
        input wrEn,
        input wrAddr,
        input wrData,
        input rdAddr,
        output rdData
    );
endinterface

/* File: core/cprm_flag.sv */
/*
 * Sticky flag: set by hardware, cleared by an access.
 * Assumes set and clr are one-cycle pulses on clk.
 */
`timescale 1ns/1ps
module cprm_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic flag_ff;

    // set wins so an event landing on the clearing access survives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (set) begin
            flag_ff <= 1'b1;
        end else if (clr) begin
            flag_ff <= 1'b0;
        end
    end

    assign q = flag_ff;
endmodule

/* File: core/cprm_id_mem.sv */
/*
 * Byte store for the downstream receiver id list.
 * Assumes one writer and one reader on clk; read data registered.
 */
`timescale 1ns/1ps
`include "cprm_cfg.svh"
module cprm_id_mem (
    input wire logic clk,
    cprm_mem_if.mem port
);
    logic [7:0] store [`CPRM_LIST_DEPTH];
    logic [7:0] rdData_ff;

    // no reset: contents are meaningless until the list is written
    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            store[port.wrAddr] <= port.wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdData_ff <= store[port.rdAddr];
    end

    assign port.rdData = rdData_ff;
endmodule

/* File: core/cprm_top.sv */
/*
 * Receiver register tail (message window, capabilities) and the
 * repeater mailbox through which the downstream processor hands
 * over the id list, topology word and role, and reads stream type.
 * Assumes both register ports and the core side run on clk, and
 * that requests are single-cycle strobes.
 */
`timescale 1ns/1ps
`include "cprm_cfg.svh"

// Notes on behaviour
// - message window moves one byte per access in bits 7:0, bursts allowed
// - capability bits 23:16 report protocol version two
// - capability bit 1 always reads one: newer revision supported
// - capability bits 15:2 always read zero
// - capability bit 0 is zero as endpoint, one as repeater
// - core raises request bit 18 when it needs data; ready then set
// - core raises ready bit 17 after processing the previous data
// - core clears valid bit 16 itself after reading the data
// - topology word: depth 11:9, count 8:4, flags 3:0, 15:12 reserved
// - type valid bit 8 set on new type, cleared when type read
// - type 0x00 is type 0; 0x01 and above mean type 1
// - repeater port: writes take no wait, reads one wait cycle
module cprm_top (
    input wire logic clk,
    input wire logic rst,
    // upstream-facing register port
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    // message bytes toward and from the protocol engine
    output logic [7:0] msgWrByte,
    output logic msgWrStrobe,
    input wire logic [7:0] msgRdByte,
    output logic msgRdStrobe,
    // repeater message port
    input wire logic [7:0] rptAddr,
    input wire logic rptWr,
    input wire logic rptRd,
    input wire logic [31:0] rptWrData,
    output logic [31:0] rptRdData,
    // protocol engine side of the mailbox
    input wire logic listRequest,
    input wire logic listConsumed,
    input wire logic [7:0] listRdAddr,
    output logic [7:0] listRdData,
    output logic [7:0] listLength,
    output logic topologyValid,
    output logic [15:0] topologyInfo,
    output logic [2:0] cascadeDepth,
    output logic [4:0] deviceCount,
    output logic tooManyDevices,
    output logic cascadeLimit,
    output logic newRevRepeaterBelow,
    output logic oldRevDeviceBelow,
    input wire logic [7:0] typeIn,
    input wire logic typeLoad,
    output logic streamIsType1,
    output logic repeaterMode
);
    cprm_pkg::cprm_mb_state_t state_ff;
    cprm_pkg::cprm_mb_state_t nxt_state;
    cprm_pkg::cprm_topology_t topo_ff;
    logic processed_ff;
    logic role_ff;
    logic [7:0] type_ff;
    logic [8:0] listPtr_ff;
    logic [31:0] regRdData_ff;
    logic [31:0] rptRdData_ff;
    logic [7:0] msgWrByte_ff;
    logic msgWrStrobe_ff;
    logic request;
    logic ready;
    logic validQ;
    logic typeValidQ;
    logic listWrHit;
    logic topoWrHit;
    logic validWrite;
    logic typeReadHit;
    logic consume;
    logic [31:0] capsWord;
    logic [31:0] topoWord;
    logic [31:0] typeWord;

    cprm_mem_if memBus ();

    // upstream register port: message window and capabilities

    // each access moves exactly one byte, so a burst is repeated access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msgWrByte_ff <= 8'h00;
            msgWrStrobe_ff <= 1'b0;
        end else begin
            msgWrStrobe_ff <= regWr && (regAddr == `CPRM_MSG_IDX);
            if (regWr && (regAddr == `CPRM_MSG_IDX)) begin
                msgWrByte_ff <= regWrData[7:0];
            end
        end
    end

    assign msgWrByte = msgWrByte_ff;
    assign msgWrStrobe = msgWrStrobe_ff;
    // engine advances to the next byte on every window read
    assign msgRdStrobe = regRd && (regAddr == `CPRM_MSG_IDX);

    always_comb begin
        capsWord = `CPRM_ZERO_RST;
        capsWord[`CPRM_VER_LSB +: 8] = `CPRM_VERSION;
        capsWord[`CPRM_NEWREV_BIT] = 1'b1;
        capsWord[`CPRM_ROLE_BIT] = role_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData_ff <= `CPRM_ZERO_RST;
        end else if (regRd) begin
            case (regAddr)
                `CPRM_MSG_IDX: regRdData_ff <= {24'h000000, msgRdByte};
                `CPRM_CAPS_IDX: regRdData_ff <= capsWord;
                default: regRdData_ff <= `CPRM_ZERO_RST;
            endcase
        end
    end

    assign regRdData = regRdData_ff;

    // repeater port decode; addresses are word indices
    assign listWrHit = rptWr && (rptAddr == `CPRM_LIST_IDX);
    assign topoWrHit = rptWr && (rptAddr == `CPRM_TOPO_IDX);
    assign typeReadHit = rptRd && (rptAddr == `CPRM_TYPE_IDX);
    // a hand-over is only accepted while ready shows one
    assign validWrite = topoWrHit && rptWrData[`CPRM_VLD_BIT] && ready;
    assign consume = listConsumed && validQ;

    // mailbox handshake state

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            cprm_pkg::MB_IDLE: begin
                if (listRequest) begin
                    nxt_state = cprm_pkg::MB_WAIT;
                end
            end
            cprm_pkg::MB_WAIT: begin
                if (validWrite) begin
                    nxt_state = cprm_pkg::MB_FULL;
                end
            end
            cprm_pkg::MB_FULL: begin
                if (consume) begin
                    nxt_state = cprm_pkg::MB_IDLE;
                end
            end
            default: nxt_state = cprm_pkg::MB_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= cprm_pkg::MB_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign request = (state_ff != cprm_pkg::MB_IDLE);

    // processed: set once the core has used the last hand-over
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            processed_ff <= 1'b0;
        end else if (consume) begin
            processed_ff <= 1'b1;
        end else if (validWrite) begin
            processed_ff <= 1'b0;
        end
    end

    // ready can never be low while a request stands
    assign ready = processed_ff || request;

    cprm_flag u_topoValid (
        .clk(clk),
        .rst(rst),
        .set(validWrite),
        .clr(consume),
        .q(validQ)
    );

    // topology word is latched together with the valid mark
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            topo_ff <= `CPRM_TOPO_RST;
        end else if (validWrite) begin
            topo_ff <= rptWrData[15:0];
        end
    end

    assign topologyValid = validQ;
    assign topologyInfo = topo_ff;
    assign cascadeDepth = topo_ff.cascadeDepth;
    assign deviceCount = topo_ff.deviceCount;
    assign tooManyDevices = topo_ff.too_many_devices_flag;
    assign cascadeLimit = topo_ff.cascade_limit_flag;
    assign newRevRepeaterBelow = topo_ff.new_rev_repeater_below;
    assign oldRevDeviceBelow = topo_ff.old_rev_device_below;

    // id list bytes, stored in arrival order: first byte is the msb

    // pointer restarts after each use so the next list starts at zero;
    // bytes past CPRM_LIST_LIMIT, outside a ready window or while valid is set are dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            listPtr_ff <= 9'h000;
        end else if (consume) begin
            listPtr_ff <= 9'h000;
        end else if (listWrHit && ready && !validQ
                     && (listPtr_ff < `CPRM_LIST_LIMIT)) begin
            listPtr_ff <= listPtr_ff + 9'h001;
        end
    end


    always_comb begin
        memBus.wrEn = listWrHit && ready && !validQ
                      && (listPtr_ff < `CPRM_LIST_LIMIT);
        memBus.wrAddr = listPtr_ff[7:0];
        memBus.wrData = rptWrData[7:0];
        memBus.rdAddr = listRdAddr;
    end

    cprm_id_mem u_idMem (
        .clk(clk),
        .port(memBus.mem)
    );

    assign listRdData = memBus.rdData;
    assign listLength = listPtr_ff[7:0];

    // content stream type

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            type_ff <= `CPRM_TYPE_RST;
        end else if (typeLoad) begin
            type_ff <= typeIn;
        end
    end

    cprm_flag u_typeValid (
        .clk(clk),
        .rst(rst),
        .set(typeLoad),
        .clr(typeReadHit),
        .q(typeValidQ)
    );

    // reserved codes fold into type 1
    assign streamIsType1 = (type_ff != 8'h00);

    // downstream role written by the processor

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            role_ff <= 1'b0;
        end else if (rptWr && (rptAddr == `CPRM_ROLE_IDX)) begin
            role_ff <= rptWrData[`CPRM_ROLE_BIT];
        end
    end

    assign repeaterMode = role_ff;

    // repeater port read path

    always_comb begin
        topoWord = `CPRM_ZERO_RST;
        topoWord[`CPRM_REQ_BIT] = request;
        topoWord[`CPRM_RDY_BIT] = ready;
        topoWord[`CPRM_VLD_BIT] = validQ;
        topoWord[15:0] = topo_ff;
        typeWord = `CPRM_ZERO_RST;
        typeWord[`CPRM_TYPE_VLD_BIT] = typeValidQ;
        typeWord[7:0] = type_ff;
    end

    // data registered on the request edge: one wait cycle for reads,
    // writes take effect on the same edge with no wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rptRdData_ff <= `CPRM_ZERO_RST;
        end else if (rptRd) begin
            case (rptAddr)
                `CPRM_TOPO_IDX: rptRdData_ff <= topoWord;
                `CPRM_TYPE_IDX: rptRdData_ff <= typeWord;
                `CPRM_ROLE_IDX: rptRdData_ff <= {31'h00000000, role_ff};
                default: rptRdData_ff <= `CPRM_ZERO_RST;
            endcase
        end
    end

    assign rptRdData = rptRdData_ff;
endmodule

/* File: tb/cprm_top_assertions.sv */
/*
 * Port checks of cprm_top.
 * Assumes one clock and single-cycle strobes on both register ports.
 */
`timescale 1ns/1ps
module cprm_top_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regWrData,
    input wire logic [31:0] regRdData,
    input wire logic [7:0] msgWrByte,
    input wire logic msgWrStrobe,
    input wire logic [7:0] msgRdByte,
    input wire logic [7:0] rptAddr,
    input wire logic rptWr,
    input wire logic rptRd,
    input wire logic [31:0] rptWrData,
    input wire logic [31:0] rptRdData,
    input wire logic listConsumed,
    input wire logic [7:0] listLength,
    input wire logic topologyValid,
    input wire logic [15:0] topologyInfo,
    input wire logic [7:0] typeIn,
    input wire logic typeLoad,
    input wire logic streamIsType1,
    input wire logic repeaterMode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_caps_read: assert property (regRd && regAddr == 8'h43 |=>
        regRdData == {16'h0002, 14'h0000, 1'b1, $past(repeaterMode)}) else $error("caps word");
    a_msg_write: assert property (regWr && regAddr == 8'h42 |=>
        msgWrStrobe && msgWrByte == 8'($past(regWrData))) else $error("message write");
    a_msg_read: assert property (regRd && regAddr == 8'h42 |=>
        regRdData == {24'h000000, $past(msgRdByte)}) else $error("message read");
    a_req_ready: assert property (rptRd && rptAddr == 8'h01 |=>
        !rptRdData[18] || rptRdData[17]) else $error("request without ready");
    a_valid_clear: assert property (listConsumed && topologyValid |=>
        !topologyValid && listLength == 8'h00) else $error("valid not cleared");
    a_valid_set: assert property ($rose(topologyValid) |-> $past(rptWr) &&
        $past(rptAddr) == 8'h01 && topologyInfo == 16'($past(rptWrData)))
        else $error("valid without write");
    a_type_class: assert property (typeLoad |=>
        streamIsType1 == ($past(typeIn) != 8'h00)) else $error("type class");
    a_type_flag: assert property (typeLoad ##1 (rptRd && rptAddr == 8'h02) |=>
        rptRdData[8] && rptRdData[7:0] == $past(typeIn, 2)) else $error("type flag");
    a_role_write: assert property (rptWr && rptAddr == 8'h03 |=>
        repeaterMode == 1'($past(rptWrData))) else $error("role bit");
endmodule

bind cprm_top cprm_top_chk i_cprm_top_chk (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
    .msgWrByte(msgWrByte), .msgWrStrobe(msgWrStrobe), .msgRdByte(msgRdByte),
    .rptAddr(rptAddr), .rptWr(rptWr), .rptRd(rptRd), .rptWrData(rptWrData),
    .rptRdData(rptRdData), .listConsumed(listConsumed), .listLength(listLength),
    .topologyValid(topologyValid), .topologyInfo(topologyInfo), .typeIn(typeIn),
    .typeLoad(typeLoad), .streamIsType1(streamIsType1), .repeaterMode(repeaterMode));

/* File: tb/cprm_proc_model.sv */
/*
 * Downstream processor model on the repeater port.
 * Assumes read data registered, valid the cycle after the read edge.
 */
`timescale 1ns/1ps
module cprm_proc_model (
    input wire logic clk,
    input wire logic [31:0] rptRdData,
    output logic [7:0] rptAddr,
    output logic rptWr,
    output logic rptRd,
    output logic [31:0] rptWrData
);
    initial begin
        rptAddr = 8'h00;
        rptWr = 1'b0;
        rptRd = 1'b0;
        rptWrData = 32'h00000000;
    end
    // word index straight onto the address, no byte scaling
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        rptAddr <= a;
        rptWrData <= d;
        rptWr <= 1'b1;
        @(posedge clk);
        rptWr <= 1'b0;
        // released data must not look held
        rptWrData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        rptAddr <= a;
        rptRd <= 1'b1;
        @(posedge clk);
        rptRd <= 1'b0;
        #1;
        q = rptRdData;
    endtask
    task automatic load(input logic [39:0] ids, input logic [15:0] topo);
        logic [31:0] q;
        q = 32'h00000000;
        for (int k = 0; k < 20 && !q[17]; k++) begin
            rd(8'h01, q);
        end
        for (int i = 4; i >= 0; i--) begin
            wr(8'h00, {24'h000000, ids[i*8 +: 8]});
        end
        wr(8'h01, {16'h0001, topo});
    endtask
endmodule

/* File: tb/tb.sv */
/*
 * Self-checking bench of cprm_top.
 * Assumes the processor model drives the repeater port.
 */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, listRequest = 1'b0;
    logic listConsumed = 1'b0, typeLoad = 1'b0, msgWrStrobe, msgRdStrobe, rptWr, rptRd;
    logic topologyValid, tooManyDevices, cascadeLimit, newRevRepeaterBelow;
    logic oldRevDeviceBelow, streamIsType1, repeaterMode;
    logic [7:0] regAddr = 8'h00, msgRdByte = 8'h00, listRdAddr = 8'h00, typeIn = 8'h00;
    logic [7:0] msgWrByte, rptAddr, listRdData, listLength;
    logic [31:0] regWrData = 32'h00000000, regRdData, rptWrData, rptRdData;
    logic [15:0] topologyInfo;
    logic [2:0] cascadeDepth;
    logic [4:0] deviceCount;
    integer errTotal = 0;
    integer checksDone = 0;

    always #12.5 clk = ~clk;
    // core-side pulses last one cycle
    always @(posedge clk) begin
        if (typeLoad) typeLoad <= 1'b0;
        if (listRequest) listRequest <= 1'b0;
        if (listConsumed) listConsumed <= 1'b0;
    end

    cprm_top i_cprm_top (.clk(clk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
        .msgWrByte(msgWrByte), .msgWrStrobe(msgWrStrobe), .msgRdByte(msgRdByte),
        .msgRdStrobe(msgRdStrobe), .rptAddr(rptAddr), .rptWr(rptWr), .rptRd(rptRd),
        .rptWrData(rptWrData), .rptRdData(rptRdData), .listRequest(listRequest),
        .listConsumed(listConsumed), .listRdAddr(listRdAddr), .listRdData(listRdData),
        .listLength(listLength), .topologyValid(topologyValid),
        .topologyInfo(topologyInfo), .cascadeDepth(cascadeDepth),
        .deviceCount(deviceCount), .tooManyDevices(tooManyDevices),
        .cascadeLimit(cascadeLimit), .newRevRepeaterBelow(newRevRepeaterBelow),
        .oldRevDeviceBelow(oldRevDeviceBelow), .typeIn(typeIn), .typeLoad(typeLoad),
        .streamIsType1(streamIsType1), .repeaterMode(repeaterMode));
    cprm_proc_model i_cprm_proc_model (.clk(clk), .rptRdData(rptRdData),
        .rptAddr(rptAddr), .rptWr(rptWr), .rptRd(rptRd), .rptWrData(rptWrData));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rg(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        q = regRdData;
    endtask
    task automatic t_caps();
        logic [31:0] q;
        rw(8'h43, 32'hFFFFFFFF);
        rg(8'h43, q);
        chk("caps", 32'h00020002, q);
        rg(8'h44, q);
        chk("unmapped", 32'h00000000, q);
    endtask
    task automatic t_msg();
        logic [31:0] q;
        logic [7:0] b [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h00};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            regAddr <= 8'h42;
            regWr <= (i < 3);
            regWrData <= {24'hFFFFFF, b[i]};
            msgRdByte <= 8'h5A;
            #1;
            if (i > 0) chk("msgWr", {23'h0, 1'b1, b[i-1]}, {23'h0, msgWrStrobe, msgWrByte});
        end
        @(posedge clk);
        regRd <= 1'b1;
        #1;
        chk("msgRdStrobe", 32'h1, {31'h0, msgRdStrobe});
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        q = regRdData;
        chk("msgRd", 32'h0000005A, q);
    endtask
    task automatic t_mbox();
        logic [31:0] q;
        i_cprm_proc_model.wr(8'h00, 32'h000000EE);
        #1;
        chk("refused", 32'h0, {24'h0, listLength});
        @(posedge clk) listRequest <= 1'b1;
        i_cprm_proc_model.rd(8'h01, q);
        chk("request", 32'h00060000, q);
        i_cprm_proc_model.load(40'h1122334455, 16'h062A);
        #1;
        chk("valid", 32'h1, {31'h0, topologyValid});
        chk("topo", 32'h062A, {16'h0, topologyInfo});
        chk("fields", 32'h062A, {20'h0, cascadeDepth, deviceCount, tooManyDevices,
            cascadeLimit, newRevRepeaterBelow, oldRevDeviceBelow});
        chk("len", 32'h5, {24'h0, listLength});
        @(posedge clk) listRdAddr <= 8'h04;
        repeat (2) @(posedge clk);
        #1;
        chk("lastByte", 32'h55, {24'h0, listRdData});
        i_cprm_proc_model.rd(8'h01, q);
        chk("held", 32'h0007062A, q);
        @(posedge clk) listConsumed <= 1'b1;
        i_cprm_proc_model.rd(8'h01, q);
        chk("consumed", 32'h2, {29'h0, q[18:16]});
    endtask
    task automatic t_type();
        logic [31:0] q;
        logic [7:0] tv [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
        foreach (tv[i]) begin
            @(posedge clk);
            typeIn <= tv[i];
            typeLoad <= 1'b1;
            i_cprm_proc_model.rd(8'h02, q);
            chk("typeNew", {23'h0, 1'b1, tv[i]}, q);
            chk("typeOne", {31'h0, tv[i] != 8'h00}, {31'h0, streamIsType1});
            i_cprm_proc_model.rd(8'h02, q);
            chk("typeSeen", {24'h0, tv[i]}, q);
        end
    endtask
    task automatic t_role();
        logic [31:0] q;
        for (int v = 1; v >= 0; v--) begin
            i_cprm_proc_model.wr(8'h03, {31'h0, v[0]});
            rg(8'h43, q);
            chk("capsRole", {30'h00008000, 1'b1, v[0]}, q);
            chk("roleOut", {31'h0, v[0]}, {31'h0, repeaterMode});
            i_cprm_proc_model.rd(8'h03, q);
            chk("role", {31'h0, v[0]}, q);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_caps();
        t_msg();
        t_mbox();
        t_type();
        t_role();
        final_report();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        errTotal++;
        final_report();
    end
endmodule
